// File: irq_pkg.sv
/*
 Constants for the external-line and pin-change interrupt block:
 register offsets, field positions, sense encodings and reset values.
 Assumes an APB slave with 32-bit data and byte addressing.
*/
package irq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LINES = 2;
	localparam int GROUP_W = 8;
	localparam int SRC_N = 4;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_EXT_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_EXT_FLAG = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_GRP_EN = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_GRP_FLAG = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MASK_HIGH = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK_LOW = 8'h18;

	// ----------------------------------------
	// field positions and request indices
	// ----------------------------------------
	localparam int LINE_A = 0;
	localparam int LINE_B = 1;
	localparam int GRP_LOW = 0;
	localparam int GRP_HIGH = 1;
	localparam int SRC_EXT_A = 0;
	localparam int SRC_EXT_B = 1;
	localparam int SRC_CHG_LOW = 2;
	localparam int SRC_CHG_HIGH = 3;
	localparam int SENSE_W = 2;

	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_ANY = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

	typedef enum {
		SEL_SENSE, SEL_EXT_EN, SEL_EXT_FLAG, SEL_GRP_EN,
		SEL_GRP_FLAG, SEL_MASK_HIGH, SEL_MASK_LOW, SEL_NONE
	} reg_sel_type;
endpackage

// File: ext_pin_irq_ctrl.sv
/*
 External-line and pin-change interrupt controller with APB registers.
 Assumes: pins arrive asynchronously; the core supplies its global
 interrupt enable and a one-cycle acknowledge on sys_clk.
*/
// The address map and the APB slave port were chosen for this implementation.
// Notes on behaviour
// - unused register bits always read zero
// - line B request needs enable and global
// - line A request needs enable and global
// - sense bits pick rise, fall, change, low
// - pins trigger even when driven as outputs
// - selected edge sets the line's flag
// - flag plus enables signals the core vector
// - core acknowledge clears the source's flag
// - writing one clears flag, zero keeps
// - low-level mode keeps line flag zero
// - high group needs enable and global
// - low group needs enable and global
// - unmasked pin change sets group flag
// - high mask bits gate pins 15..8
// - low mask bits gate pins 7..0
// - sense codes 00 low 01 any 10 fall 11 rise
// - low level keeps requesting while held low
// - pins sampled, pulses over one clock caught
// - pin change wakes without a running clock
module ext_pin_irq_ctrl
	import irq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [LINES-1:0] ext_pins,
	input wire logic [GROUP_W-1:0] change_inputs_low,
	input wire logic [GROUP_W-1:0] change_inputs_high,
	input wire logic core_irq_enable,
	input wire logic irq_ack,
	input wire logic [1:0] irq_ack_id,
	output logic [SRC_N-1:0] irq_request,
	output logic change_wake
);
	localparam int PIN_N = LINES + 2 * GROUP_W;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [PIN_N-1:0] sync1;
		logic [PIN_N-1:0] sync2;
		logic [PIN_N-1:0] prev;
		logic [2*SENSE_W-1:0] sense;
		logic [LINES-1:0] ext_en;
		logic [LINES-1:0] ext_flag;
		logic [1:0] grp_en;
		logic [1:0] grp_flag;
		logic [GROUP_W-1:0] mask_high;
		logic [GROUP_W-1:0] mask_low;
		logic [SRC_N-1:0] irq;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic err;
	} state_type;

	state_type s_q, s_d;

	function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFS_SENSE: decode = SEL_SENSE;
			OFS_EXT_EN: decode = SEL_EXT_EN;
			OFS_EXT_FLAG: decode = SEL_EXT_FLAG;
			OFS_GRP_EN: decode = SEL_GRP_EN;
			OFS_GRP_FLAG: decode = SEL_GRP_FLAG;
			OFS_MASK_HIGH: decode = SEL_MASK_HIGH;
			OFS_MASK_LOW: decode = SEL_MASK_LOW;
			default: decode = SEL_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// detection on synchronised samples
	// ----------------------------------------
	logic [LINES-1:0] cur_ext, prv_ext, edge_ev, level_low;
	logic [GROUP_W-1:0] cur_lo, prv_lo, cur_hi, prv_hi;
	logic [1:0] grp_ev;
	logic wr_en, setup;
	reg_sel_type sel;

	// each pin goes sync1 -> sync2 -> prev; detection compares sync2 with prev,
	// so an edge reaches its flag two clocks after sync1 first sees it.
	// a pin already high when reset ends looks like a rising edge once the
	// pipeline fills; software should clear the flags after setting up.
	assign cur_ext = s_q.sync2[LINES-1:0];
	assign prv_ext = s_q.prev[LINES-1:0];
	assign cur_lo = s_q.sync2[LINES +: GROUP_W];
	assign prv_lo = s_q.prev[LINES +: GROUP_W];
	assign cur_hi = s_q.sync2[LINES+GROUP_W +: GROUP_W];
	assign prv_hi = s_q.prev[LINES+GROUP_W +: GROUP_W];

	// pins are read regardless of their port direction
	generate
		for (genvar i = 0; i < LINES; i++) begin : g_line
			logic [1:0] mode;
			assign mode = s_q.sense[i*SENSE_W +: SENSE_W];
			always_comb begin
				unique case (mode)
					SENSE_ANY: edge_ev[i] = cur_ext[i] ^ prv_ext[i];
					SENSE_FALL: edge_ev[i] = prv_ext[i] & ~cur_ext[i];
					SENSE_RISE: edge_ev[i] = cur_ext[i] & ~prv_ext[i];
					default: edge_ev[i] = 1'b0;
				endcase
			end
			assign level_low[i] = (mode == SENSE_LOW) & ~cur_ext[i];
		end
	endgenerate

	assign grp_ev[GRP_LOW] = |(s_q.mask_low & (cur_lo ^ prv_lo));
	assign grp_ev[GRP_HIGH] = |(s_q.mask_high & (cur_hi ^ prv_hi));

	// clockless wake path: raw pins against the prev stage, the oldest clocked sample
	// limitation: it only wakes the clock; the group flag still needs sys_clk
	// to set, so a change that is undone before the clock runs is lost
	assign change_wake = |(s_q.mask_low & (change_inputs_low ^ prv_lo))
		| |(s_q.mask_high & (change_inputs_high ^ prv_hi));

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// register map, one word each, data in the low bits:
	//   0x00 sense, two bits per line, line A lowest
	//   0x04 line enables, 0x08 line flags (write one to clear)
	//   0x0C group enables, 0x10 group flags (write one to clear)
	//   0x14 high group mask, 0x18 low group mask
	// unmapped addresses answer with pslverr and read as zero
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & s_q.ready;
	assign sel = decode(paddr);

	always_comb begin
		logic [LINES-1:0] ext_clr;
		logic [1:0] grp_clr;
		logic [1:0] mode_a;
		logic [1:0] mode_b;
		ext_clr = '0;
		grp_clr = '0;
		s_d = s_q;
		mode_a = s_q.sense[LINE_A*SENSE_W +: SENSE_W];
		mode_b = s_q.sense[LINE_B*SENSE_W +: SENSE_W];
		s_d.sync1 = {change_inputs_high, change_inputs_low, ext_pins};
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;

		if (wr_en) begin
			unique case (sel)
				SEL_SENSE: s_d.sense = pwdata[2*SENSE_W-1:0];
				SEL_EXT_EN: s_d.ext_en = pwdata[LINES-1:0];
				SEL_EXT_FLAG: ext_clr = pwdata[LINES-1:0];
				SEL_GRP_EN: s_d.grp_en = pwdata[1:0];
				SEL_GRP_FLAG: grp_clr = pwdata[1:0];
				SEL_MASK_HIGH: s_d.mask_high = pwdata[GROUP_W-1:0];
				SEL_MASK_LOW: s_d.mask_low = pwdata[GROUP_W-1:0];
				SEL_NONE: ;
			endcase
		end
		if (irq_ack) begin
			unique case (irq_ack_id)
				2'h0: ext_clr[LINE_A] = 1'b1;
				2'h1: ext_clr[LINE_B] = 1'b1;
				2'h2: grp_clr[GRP_LOW] = 1'b1;
				2'h3: grp_clr[GRP_HIGH] = 1'b1;
			endcase
		end
		// a set in the clearing cycle wins
		s_d.ext_flag = (s_q.ext_flag & ~ext_clr) | edge_ev;
		s_d.grp_flag = (s_q.grp_flag & ~grp_clr) | grp_ev;
		if (mode_a == SENSE_LOW)
			s_d.ext_flag[LINE_A] = 1'b0;
		if (mode_b == SENSE_LOW)
			s_d.ext_flag[LINE_B] = 1'b0;

		// requests toward the core vector logic; the register reads the
		// global enable one clock late, so a request may outlive it by a cycle
		// acknowledge ids follow the request bit numbering
		s_d.irq[SRC_EXT_A] = core_irq_enable & s_q.ext_en[LINE_A]
			& (s_q.ext_flag[LINE_A] | level_low[LINE_A]);
		s_d.irq[SRC_EXT_B] = core_irq_enable & s_q.ext_en[LINE_B]
			& (s_q.ext_flag[LINE_B] | level_low[LINE_B]);
		s_d.irq[SRC_CHG_LOW] = core_irq_enable & s_q.grp_en[GRP_LOW]
			& s_q.grp_flag[GRP_LOW];
		s_d.irq[SRC_CHG_HIGH] = core_irq_enable & s_q.grp_en[GRP_HIGH]
			& s_q.grp_flag[GRP_HIGH];

		// apb: answer in the first access cycle
		s_d.ready = setup;
		s_d.err = setup & (sel == SEL_NONE);
		s_d.rdata = DATA_ZERO;
		if (setup & ~pwrite) begin
			unique case (sel)
				SEL_SENSE: s_d.rdata[2*SENSE_W-1:0] = s_q.sense;
				SEL_EXT_EN: s_d.rdata[LINES-1:0] = s_q.ext_en;
				SEL_EXT_FLAG: s_d.rdata[LINES-1:0] = s_q.ext_flag;
				SEL_GRP_EN: s_d.rdata[1:0] = s_q.grp_en;
				SEL_GRP_FLAG: s_d.rdata[1:0] = s_q.grp_flag;
				SEL_MASK_HIGH: s_d.rdata[GROUP_W-1:0] = s_q.mask_high;
				SEL_MASK_LOW: s_d.rdata[GROUP_W-1:0] = s_q.mask_low;
				SEL_NONE: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.mask_high <= REG_RESET;
			s_q.mask_low <= REG_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.err;
	assign irq_request = s_q.irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	AST_RESERVED_ZERO: assert property (prdata[DATA_W-1:GROUP_W] == '0)
		else $error("reserved read bits not zero");
	AST_FLAG_READ_ZERO: assert property ($past(setup) && !$past(pwrite)
		&& ($past(sel) == SEL_EXT_FLAG || $past(sel) == SEL_GRP_FLAG)
		|-> prdata[DATA_W-1:LINES] == '0)
		else $error("flag read shows unused bits");
	AST_UNMAPPED_READ: assert property ($past(setup) && $past(sel) == SEL_NONE
		|-> prdata == '0 && pslverr)
		else $error("unmapped access not refused");

	// ----------------------------------------
	// request gating
	// ----------------------------------------
	AST_LINE_B_GATE: assert property (irq_request[SRC_EXT_B]
		|-> $past(core_irq_enable) && $past(s_q.ext_en[LINE_B]))
		else $error("line b request without enables");
	AST_LINE_A_GATE: assert property (irq_request[SRC_EXT_A]
		|-> $past(core_irq_enable) && $past(s_q.ext_en[LINE_A]))
		else $error("line a request without enables");
	AST_GRP_HIGH_GATE: assert property (irq_request[SRC_CHG_HIGH]
		|-> $past(core_irq_enable) && $past(s_q.grp_en[GRP_HIGH]))
		else $error("high group request without enables");
	AST_GRP_LOW_GATE: assert property (irq_request[SRC_CHG_LOW]
		|-> $past(core_irq_enable) && $past(s_q.grp_en[GRP_LOW]))
		else $error("low group request without enables");
	AST_GLOBAL_OFF: assert property (!core_irq_enable |=> irq_request == '0)
		else $error("request with global enable off");

	// ----------------------------------------
	// edge sensing
	// ----------------------------------------
	AST_RISE_SETS: assert property (s_q.sense[1:0] == SENSE_RISE
		&& cur_ext[LINE_A] && !prv_ext[LINE_A] |=> s_q.ext_flag[LINE_A])
		else $error("rising edge did not set flag");
	AST_FALL_SETS: assert property (s_q.sense[3:2] == SENSE_FALL
		&& prv_ext[LINE_B] && !cur_ext[LINE_B] |=> s_q.ext_flag[LINE_B])
		else $error("falling edge did not set flag");
	AST_ANY_SETS: assert property (s_q.sense[1:0] == SENSE_ANY
		&& (cur_ext[LINE_A] ^ prv_ext[LINE_A]) |=> s_q.ext_flag[LINE_A])
		else $error("change did not set flag");
	AST_FALL_IGNORES_RISE: assert property (s_q.sense[1:0] == SENSE_FALL
		&& !s_q.ext_flag[LINE_A] && !(prv_ext[LINE_A] && !cur_ext[LINE_A])
		|=> !s_q.ext_flag[LINE_A])
		else $error("wrong edge set flag");

	// ----------------------------------------
	// flags, acknowledge and clearing
	// ----------------------------------------
	AST_FLAG_TO_REQ: assert property (core_irq_enable && s_q.grp_en[GRP_LOW]
		&& s_q.grp_flag[GRP_LOW] |=> irq_request[SRC_CHG_LOW])
		else $error("flag with enables gave no request");
	AST_ACK_CLEARS: assert property (irq_ack && irq_ack_id == 2'h3
		&& !grp_ev[GRP_HIGH] |=> !s_q.grp_flag[GRP_HIGH])
		else $error("acknowledge did not clear flag");
	AST_ACK_CLEARS_LOW: assert property (irq_ack && irq_ack_id == 2'h2
		&& !grp_ev[GRP_LOW] |=> !s_q.grp_flag[GRP_LOW])
		else $error("acknowledge did not clear low group flag");
	AST_ACK_CLEARS_A: assert property (irq_ack && irq_ack_id == 2'h0
		&& !edge_ev[LINE_A] |=> !s_q.ext_flag[LINE_A])
		else $error("acknowledge did not clear line a flag");
	AST_ACK_CLEARS_B: assert property (irq_ack && irq_ack_id == 2'h1
		&& !edge_ev[LINE_B] |=> !s_q.ext_flag[LINE_B])
		else $error("acknowledge did not clear line b flag");
	AST_W1C: assert property (wr_en && sel == SEL_GRP_FLAG && pwdata[GRP_LOW]
		&& !grp_ev[GRP_LOW] |=> !s_q.grp_flag[GRP_LOW])
		else $error("write one did not clear flag");
	AST_W1C_EXT: assert property (wr_en && sel == SEL_EXT_FLAG && pwdata[LINE_B]
		&& !edge_ev[LINE_B] |=> !s_q.ext_flag[LINE_B])
		else $error("write one did not clear line flag");
	AST_W1C_ZERO_KEEPS: assert property (wr_en && sel == SEL_EXT_FLAG
		&& !pwdata[LINE_A] && !irq_ack && s_q.ext_flag[LINE_A]
		&& s_q.sense[1:0] != SENSE_LOW |=> s_q.ext_flag[LINE_A])
		else $error("writing zero cleared flag");

	// ----------------------------------------
	// level sensing
	// ----------------------------------------
	AST_LEVEL_FLAG_ZERO: assert property (s_q.sense[3:2] == SENSE_LOW
		|=> !s_q.ext_flag[LINE_B])
		else $error("level mode flag not zero");
	AST_LEVEL_REQ: assert property (core_irq_enable && s_q.ext_en[LINE_A]
		&& level_low[LINE_A] |=> irq_request[SRC_EXT_A])
		else $error("held low level gave no request");
	AST_LEVEL_REQ_B: assert property (core_irq_enable && s_q.ext_en[LINE_B]
		&& level_low[LINE_B] |=> irq_request[SRC_EXT_B])
		else $error("held low level on line b gave no request");

	// ----------------------------------------
	// pin-change groups
	// ----------------------------------------
	AST_MASK_BLOCK: assert property (s_q.mask_high == '0
		&& !s_q.grp_flag[GRP_HIGH] |=> !s_q.grp_flag[GRP_HIGH])
		else $error("masked pins set high group flag");
	AST_MASK_LOW_BLOCK: assert property (s_q.mask_low == '0
		&& !s_q.grp_flag[GRP_LOW] |=> !s_q.grp_flag[GRP_LOW])
		else $error("masked pins set low group flag");
	AST_HIGH_PIN_SETS: assert property ((s_q.mask_high & (cur_hi ^ prv_hi)) != '0
		|=> s_q.grp_flag[GRP_HIGH])
		else $error("high group change did not set flag");
	AST_PIN_TO_FLAG: assert property ((s_q.mask_low & (change_inputs_low
		^ $past(change_inputs_low))) != '0
		##1 ($stable(change_inputs_low) && $stable(s_q.mask_low))
		|-> ##2 s_q.grp_flag[GRP_LOW])
		else $error("stable pin change not caught");

	// ----------------------------------------
	// synchroniser and wake path
	// ----------------------------------------
	AST_SYNC_TWO_STAGE: assert property (s_q.sync2 == $past(s_q.sync1)
		&& s_q.prev == $past(s_q.sync2))
		else $error("pin pipeline skipped a stage");
	AST_WAKE_QUIET: assert property (s_q.mask_low == '0 && s_q.mask_high == '0
		|-> !change_wake)
		else $error("wake with all pins masked");
	AST_WAKE_RAW: assert property ((s_q.mask_high & (change_inputs_high ^ prv_hi)) != '0
		|-> change_wake)
		else $error("unmasked raw change gave no wake");

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	AST_APB_READY: assert property (psel && !penable |=> pready)
		else $error("access not answered");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");

	COV_EDGE_IRQ: cover property (s_q.ext_flag[LINE_A] ##1 irq_request[SRC_EXT_A]);
	COV_GROUP_IRQ: cover property (grp_ev[GRP_HIGH] ##2 irq_request[SRC_CHG_HIGH]);
	COV_ACK: cover property (irq_ack ##1 irq_request == '0);
	COV_LEVEL: cover property (level_low[LINE_B] ##1 irq_request[SRC_EXT_B]);
	COV_WAKE: cover property (change_wake ##3 s_q.grp_flag[GRP_LOW]);
endmodule // ext_pin_irq_ctrl

// File: core_ack_model.sv
/*
 Core-side partner: acknowledges pending requests with a one-cycle pulse.
 Assumes irq_request levels on sys_clk; lowest index is served first.
*/
module core_ack_model import irq_pkg::*; (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ack_on,
	input wire logic [SRC_N-1:0] irq_request,
	output logic irq_ack,
	output logic [1:0] irq_ack_id
);
	logic [1:0] hold_q;
	// holdoff lets the acked request drop before the next look
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_ack <= 1'b0;
			irq_ack_id <= 2'h0;
			hold_q <= 2'h0;
		end else begin
			irq_ack <= 1'b0;
			if (hold_q != 2'h0) begin
				hold_q <= hold_q - 2'h1;
			end else if (ack_on && irq_request != '0) begin
				irq_ack <= 1'b1;
				irq_ack_id <= irq_request[0] ? 2'h0 : irq_request[1] ? 2'h1 :
					irq_request[2] ? 2'h2 : 2'h3;
				hold_q <= 2'h3;
			end
		end
	end
endmodule // core_ack_model

// File: test_ext_pin_irq_ctrl.sv
/*
 Self-checking bench for ext_pin_irq_ctrl.
 Assumes zero-wait APB and pin latencies of a few clocks.
*/
module test_ext_pin_irq_ctrl import irq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, gie = 1, ack_on = 0, irq_ack, change_wake;
	logic [1:0] ext_pins = 2'h3, irq_ack_id;
	logic [7:0] lo = '0, hi = '0;
	logic [SRC_N-1:0] irq_request;
	int failures = 0, total_checks = 0;
	ext_pin_irq_ctrl u_ext_pin_irq_ctrl(.sys_clk(sys_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pins(ext_pins),
		.change_inputs_low(lo), .change_inputs_high(hi), .core_irq_enable(gie),
		.irq_ack(irq_ack), .irq_ack_id(irq_ack_id), .irq_request(irq_request),
		.change_wake(change_wake));
	core_ack_model u_core_ack_model(.sys_clk(sys_clk), .reset(reset), .ack_on(ack_on),
		.irq_request(irq_request), .irq_ack(irq_ack), .irq_ack_id(irq_ack_id));
	initial forever #10 sys_clk = ~sys_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s got %h", $time, m, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do @(posedge sys_clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input string m);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x, m);
	endtask
	// polls a request bit, bounded, so a late answer still fails
	task req(input int i, input logic v, input string m);
		repeat (8) begin
			@(posedge sys_clk);
			if (irq_request[i] === v) break;
		end
		chk({31'h0, irq_request[i]}, {31'h0, v}, m);
	endtask
	task s_regs;
		logic [31:0] r;
		logic e;
		rd(OFS_MASK_LOW, 32'h0, "mask reset");
		wr(OFS_SENSE, 32'hFFFFFFFF);
		rd(OFS_SENSE, 32'hF, "sense unused bits");
		wr(OFS_GRP_EN, 32'hFFFFFFFF);
		rd(OFS_GRP_EN, 32'h3, "group enable unused");
		wr(OFS_GRP_EN, 32'h0);
		apb(1'b0, 8'h1C, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped read");
	endtask
	task s_edge;
		wr(OFS_SENSE, 32'h3);
		wr(OFS_EXT_EN, 32'h1);
		@(posedge sys_clk) ext_pins[0] <= 1'b0;
		repeat (5) @(posedge sys_clk);
		wr(OFS_EXT_FLAG, 32'h3);
		@(posedge sys_clk) ext_pins[0] <= 1'b1;
		req(0, 1'b1, "rise request");
		rd(OFS_EXT_FLAG, 32'h1, "rise flag");
		wr(OFS_EXT_FLAG, 32'h0);
		rd(OFS_EXT_FLAG, 32'h1, "zero keeps flag");
		wr(OFS_EXT_FLAG, 32'h1);
		rd(OFS_EXT_FLAG, 32'h0, "one clears flag");
		req(0, 1'b0, "request drops");
		wr(OFS_SENSE, 32'h2);
		gie <= 1'b0;
		@(posedge sys_clk) ext_pins[0] <= 1'b0;
		repeat (6) @(posedge sys_clk);
		rd(OFS_EXT_FLAG, 32'h1, "fall flag");
		chk({31'h0, irq_request[0]}, 32'h0, "global off");
		gie <= 1'b1;
		req(0, 1'b1, "global on");
		wr(OFS_SENSE, 32'h1);
		wr(OFS_EXT_FLAG, 32'h1);
		@(posedge sys_clk) ext_pins[0] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(OFS_EXT_FLAG, 32'h1, "any change flag");
		wr(OFS_EXT_FLAG, 32'h1);
	endtask
	task s_level;
		wr(OFS_SENSE, 32'h0);
		wr(OFS_EXT_EN, 32'h2);
		@(posedge sys_clk) ext_pins[1] <= 1'b0;
		req(1, 1'b1, "low level request");
		rd(OFS_EXT_FLAG, 32'h0, "level flag zero");
		gie <= 1'b0;
		req(1, 1'b0, "level global off");
		gie <= 1'b1;
		req(1, 1'b1, "still low");
		@(posedge sys_clk) ext_pins[1] <= 1'b1;
		req(1, 1'b0, "level released");
		wr(OFS_SENSE, 32'h8);
		@(posedge sys_clk) ext_pins[1] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(OFS_EXT_FLAG, 32'h2, "line b fall flag");
		req(1, 1'b1, "line b edge request");
		wr(OFS_EXT_FLAG, 32'h2);
		req(1, 1'b0, "line b request drops");
	endtask
	task s_change;
		wr(OFS_MASK_LOW, 32'h4);
		wr(OFS_MASK_HIGH, 32'h80);
		wr(OFS_GRP_EN, 32'h3);
		ack_on <= 1'b1;
		@(posedge sys_clk) {lo[0], hi[6]} <= 2'h3;
		repeat (6) @(posedge sys_clk);
		rd(OFS_GRP_FLAG, 32'h0, "masked pins");
		@(posedge sys_clk) lo[2] <= 1'b1;
		req(2, 1'b1, "low group request");
		req(2, 1'b0, "ack clears low");
		@(posedge sys_clk) hi[7] <= 1'b1;
		req(3, 1'b1, "high group request");
		req(3, 1'b0, "ack clears high");
		rd(OFS_GRP_FLAG, 32'h0, "group flags clear");
		chk({31'h0, change_wake}, 32'h0, "wake idle");
		gie <= 1'b0;
		@(posedge sys_clk) lo[2] <= 1'b0;
		@(posedge sys_clk);
		chk({31'h0, change_wake}, 32'h1, "wake on raw change");
		repeat (4) @(posedge sys_clk);
		rd(OFS_GRP_FLAG, 32'h1, "low flag with global off");
		chk({31'h0, irq_request[2]}, 32'h0, "low group global off");
		gie <= 1'b1;
		req(2, 1'b1, "low group global on");
		req(2, 1'b0, "ack clears again");
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		s_regs;
		s_edge;
		s_level;
		s_change;
		end_of_test;
	end
endmodule // test_ext_pin_irq_ctrl
